// ---- pkg/ptc_pkg.sv ----
// Package for the periodic timer capture / single-pulse block.
// Assumes one clock domain and a simple strobed register port.
package ptc_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] PTC_OFS_CTRL0   = 4'h0;
  localparam logic [3:0] PTC_OFS_CTRL1   = 4'h1;
  localparam logic [3:0] PTC_OFS_CMPA_L  = 4'h2;
  localparam logic [3:0] PTC_OFS_CMPA_H  = 4'h3;
  localparam logic [3:0] PTC_OFS_PER_L   = 4'h4;
  localparam logic [3:0] PTC_OFS_PER_H   = 4'h5;
  localparam logic [3:0] PTC_OFS_CNT_L   = 4'h6;
  localparam logic [3:0] PTC_OFS_CNT_H   = 4'h7;
  localparam logic [3:0] PTC_OFS_IRQ_ST  = 4'h8;
  localparam logic [3:0] PTC_OFS_IRQ_EN  = 4'h9;
  localparam logic [3:0] PTC_OFS_IRQ_CLR = 4'hA;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PTC_B_RUN    = 3;
  localparam int PTC_B_SRC    = 0;
  localparam int PTC_B_CLRSEL = 0;
  localparam int PTC_B_POL    = 1;
  localparam int PTC_B_OC     = 2;
  localparam int PTC_F_ACT_LO = 4;
  localparam int PTC_F_MODE_LO = 6;
  localparam int PTC_IRQ_A    = 0;
  localparam int PTC_IRQ_P    = 1;
  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] PTC_ACT_RISE = 2'h0;
  localparam logic [1:0] PTC_ACT_FALL = 2'h1;
  localparam logic [1:0] PTC_ACT_BOTH = 2'h2;
  localparam logic [1:0] PTC_ACT_NONE = 2'h3;
  localparam logic [7:0] PTC_RST_BYTE = 8'h00;
  localparam logic [1:0] PTC_RST_IRQ  = 2'h0;
  typedef enum logic [1:0] {
    PTC_MODE_CMP     = 2'b00,
    PTC_MODE_CAPTURE = 2'b01,
    PTC_MODE_PWM_SP  = 2'b10,
    PTC_MODE_TIMER   = 2'b11
  } ptc_mode_t;
endpackage

// ---- hdl/ptc_timer.sv ----
// Periodic timer block: capture input mode and single-shot pulse mode.
// Assumes a timer-clock tick input on i_tick and pins from outside.
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
module ptc_timer
  import ptc_pkg::*;
#(
  parameter int CNT_W = 10
)
(
  input  wire logic             i_ref_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_ce,
  input  wire logic             i_tick,
  input  wire logic [3:0]       i_addr,
  input  wire logic [7:0]       i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic      [7:0]       o_rdata,
  input  wire logic             i_capture_input_pin,
  input  wire logic             i_ext_trigger_pin,
  output logic                  o_pulse,
  output logic                  o_irq
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (CNT_W != 10)
  begin : g_bad_width
    $error("ptc_timer supports only a 10-bit counter");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] cap_sync_q;
  logic [1:0] trg_sync_q;
  logic       cap_last_q;
  logic       trg_last_q;

  // Two flops per pin, a third holds the previous sample for edges
  // Reset level matches the idle pin level so no false edge follows reset
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      cap_sync_q <= 2'h0;
      cap_last_q <= 1'b0;
    end
    else if (i_ce)
    begin
      cap_sync_q <= {cap_sync_q[0], i_capture_input_pin};
      cap_last_q <= cap_sync_q[1];
    end
  end

  // Trigger pin serves both capture source and single pulse start
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      trg_sync_q <= 2'h0;
      trg_last_q <= 1'b0;
    end
    else if (i_ce)
    begin
      trg_sync_q <= {trg_sync_q[0], i_ext_trigger_pin};
      trg_last_q <= trg_sync_q[1];
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0]       ctrl0_q;
  logic [7:0]       ctrl1_q;
  logic [CNT_W-1:0] compare_a_value_q;
  logic [CNT_W-1:0] period_value_q;
  logic [CNT_W-1:0] cnt_q;
  logic [1:0]       irq_st_q;
  logic [1:0]       irq_en_q;
  logic             run_last_q;
  logic             pulse_q;

  wire       counter_run_bit       = ctrl0_q[PTC_B_RUN];
  wire [1:0] operating_mode_field  = ctrl1_q[PTC_F_MODE_LO +: 2];
  wire [1:0] pin_action_field      = ctrl1_q[PTC_F_ACT_LO +: 2];
  wire       capture_source_select = ctrl1_q[PTC_B_SRC];
  wire       mode_cap = (operating_mode_field == PTC_MODE_CAPTURE);
  wire       mode_sp  = (operating_mode_field == PTC_MODE_PWM_SP) &&
                        (pin_action_field == PTC_ACT_NONE);

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  wire src_now  = capture_source_select ? trg_sync_q[1] : cap_sync_q[1];
  wire src_last = capture_source_select ? trg_last_q : cap_last_q;
  wire rise     = src_now & ~src_last;
  wire fall     = ~src_now & src_last;
  wire act_edge = (pin_action_field == PTC_ACT_RISE) ? rise :
                  (pin_action_field == PTC_ACT_FALL) ? fall :
                  (pin_action_field == PTC_ACT_BOTH) ? (rise | fall) : 1'b0;
  wire cap_evt  = i_ce && mode_cap && counter_run_bit && act_edge;
  wire trg_rise = trg_sync_q[1] & ~trg_last_q;
  wire sp_auto  = i_ce && mode_sp && !counter_run_bit && trg_rise;

  // ----------------------------------------------------------------
  // Counter logic
  // ----------------------------------------------------------------
  wire             run_rise  = counter_run_bit & ~run_last_q;
  wire             count_en  = i_ce && i_tick && counter_run_bit && !run_rise;
  // A zero period never matches so the counter wraps after all ones
  wire             per_match = count_en && mode_cap &&
                               (period_value_q != '0) && (cnt_q == period_value_q);
  wire             a_match   = count_en && mode_sp && (cnt_q == compare_a_value_q);
  wire [CNT_W-1:0] cnt_inc   = cnt_q + CNT_W'(1);
  wire [CNT_W-1:0] cnt_d     = run_rise  ? '0 :
                               per_match ? '0 :
                               count_en  ? cnt_inc : cnt_q;

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  // Address compares are shared by the write and read sides
  wire sel_ctrl0 = (i_addr == PTC_OFS_CTRL0);
  wire sel_ctrl1 = (i_addr == PTC_OFS_CTRL1);
  wire sel_cal   = (i_addr == PTC_OFS_CMPA_L);
  wire sel_cah   = (i_addr == PTC_OFS_CMPA_H);
  wire sel_pl    = (i_addr == PTC_OFS_PER_L);
  wire sel_ph    = (i_addr == PTC_OFS_PER_H);
  wire sel_cl    = (i_addr == PTC_OFS_CNT_L);
  wire sel_ch    = (i_addr == PTC_OFS_CNT_H);
  wire sel_st    = (i_addr == PTC_OFS_IRQ_ST);
  wire sel_en    = (i_addr == PTC_OFS_IRQ_EN);
  wire sel_clr   = (i_addr == PTC_OFS_IRQ_CLR);

  wire wr_ctrl0 = i_ce && i_wr && sel_ctrl0;
  wire wr_ctrl1 = i_ce && i_wr && sel_ctrl1;
  wire wr_cal   = i_ce && i_wr && sel_cal;
  wire wr_cah   = i_ce && i_wr && sel_cah;
  wire wr_pl    = i_ce && i_wr && sel_pl;
  wire wr_ph    = i_ce && i_wr && sel_ph;
  wire wr_en    = i_ce && i_wr && sel_en;
  wire wr_clr   = i_ce && i_wr && sel_clr;

  wire [1:0] irq_set = {per_match, cap_evt | a_match};
  wire [1:0] clr_req = wr_clr ? i_wdata[1:0] : 2'h0;
  // Set wins over a simultaneous clear so no event is lost
  wire [1:0] irq_d   = (irq_st_q & ~clr_req) | irq_set;

  wire [7:0] ctrl0_sw = wr_ctrl0 ? i_wdata : ctrl0_q;
  // Compare A match in pulse mode clears the run bit to end the pulse
  wire [7:0] ctrl0_d  = a_match ? (ctrl0_sw & ~(8'h01 << PTC_B_RUN)) :
                        sp_auto ? (ctrl0_sw | (8'h01 << PTC_B_RUN)) : ctrl0_sw;

  wire [CNT_W-1:0] cmpa_d =
    cap_evt ? cnt_q :
    wr_cal  ? {compare_a_value_q[9:8], i_wdata} :
    wr_cah  ? {i_wdata[1:0], compare_a_value_q[7:0]} : compare_a_value_q;
  wire [CNT_W-1:0] per_d =
    wr_pl ? {period_value_q[9:8], i_wdata} :
    wr_ph ? {i_wdata[1:0], period_value_q[7:0]} : period_value_q;

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  // Every register holds its value while the clock enable is low
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      ctrl0_q <= PTC_RST_BYTE;
    else if (i_ce)
      ctrl0_q <= ctrl0_d;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      ctrl1_q <= PTC_RST_BYTE;
    else if (i_ce)
      ctrl1_q <= wr_ctrl1 ? i_wdata : ctrl1_q;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      compare_a_value_q <= '0;
    else if (i_ce)
      compare_a_value_q <= cmpa_d;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      period_value_q <= '0;
    else if (i_ce)
      period_value_q <= per_d;
  end

  // Counter is never written by software, so a read never races a write
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      cnt_q <= '0;
    else if (i_ce)
      cnt_q <= cnt_d;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      irq_st_q <= PTC_RST_IRQ;
    else if (i_ce)
      irq_st_q <= irq_d;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      irq_en_q <= PTC_RST_IRQ;
    else if (i_ce)
      irq_en_q <= wr_en ? i_wdata[1:0] : irq_en_q;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      run_last_q <= 1'b0;
      pulse_q    <= 1'b0;
    end
    else if (i_ce)
    begin
      run_last_q <= counter_run_bit;
      // Pulse follows the run bit only in single pulse mode
      pulse_q    <= mode_sp && ctrl0_d[PTC_B_RUN];
    end
  end

  // ----------------------------------------------------------------
  // Read data and interrupt
  // ----------------------------------------------------------------
  // Clear register is write-only and reads back as zero
  wire [7:0] rd_mux =
    sel_ctrl0 ? ctrl0_q :
    sel_ctrl1 ? ctrl1_q :
    sel_cal   ? compare_a_value_q[7:0] :
    sel_cah   ? {6'h00, compare_a_value_q[9:8]} :
    sel_pl    ? period_value_q[7:0] :
    sel_ph    ? {6'h00, period_value_q[9:8]} :
    sel_cl    ? cnt_q[7:0] :
    sel_ch    ? {6'h00, cnt_q[9:8]} :
    sel_st    ? {6'h00, irq_st_q} :
    sel_en    ? {6'h00, irq_en_q} : 8'h00;

  // Reads outside a strobe return zero, but o_rdata keeps its last byte while the clock enable is low

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      o_rdata <= 8'h00;
    else if (i_ce)
      o_rdata <= i_rd ? rd_mux : 8'h00;
  end

  assign o_irq   = |(irq_st_q & irq_en_q);
  assign o_pulse = pulse_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  // Checks look at settled register state; they stay quiet while reset is held

  // ----------------------------------------------------------------
  // Capture checks
  // ----------------------------------------------------------------
  capture_value_a: assert property (cap_evt |=> compare_a_value_q == $past(cnt_q))
    else $error("Capture did not store counter");
  capture_flag_a: assert property (cap_evt |=> irq_st_q[PTC_IRQ_A])
    else $error("Capture flag not raised");
  no_cap_none_a: assert property (pin_action_field == PTC_ACT_NONE |-> !cap_evt)
    else $error("Capture with edges disabled");
  cap_hold_a: assert property (!cap_evt && !wr_cal && !wr_cah |=> $stable(compare_a_value_q))
    else $error("Compare A changed without cause");

  // ----------------------------------------------------------------
  // Counter checks
  // ----------------------------------------------------------------
  period_clear_a: assert property (per_match |=> cnt_q == '0 && irq_st_q[PTC_IRQ_P])
    else $error("Period match did not clear");
  zero_period_a: assert property (period_value_q == '0 |-> !per_match)
    else $error("Zero period cleared counter");
  stop_hold_a: assert property (i_ce && !counter_run_bit |=> cnt_q == $past(cnt_q))
    else $error("Counter moved while stopped");
  start_zero_a: assert property (i_ce && run_rise |=> cnt_q == '0)
    else $error("Counter not zeroed at start");
  count_step_a: assert property (count_en && !per_match |=> cnt_q == $past(cnt_q) + CNT_W'(1))
    else $error("Counter did not advance");
  wrap_full_a: assert property (count_en && period_value_q == '0 && cnt_q == '1 |=> cnt_q == '0)
    else $error("Counter did not wrap at full range");
  per_hold_a: assert property (!wr_pl && !wr_ph |=> $stable(period_value_q))
    else $error("Period changed without write");
  per_high_a: assert property (wr_ph |=> period_value_q[9:8] == $past(i_wdata[1:0]))
    else $error("Period high bits not stored");

  // ----------------------------------------------------------------
  // Pulse and interrupt checks
  // ----------------------------------------------------------------
  cap_no_out_a: assert property (mode_cap |-> ##1 !o_pulse)
    else $error("Output active in capture mode");
  sp_trigger_a: assert property (sp_auto |=> counter_run_bit ##1 o_pulse)
    else $error("Trigger pin did not start pulse");
  sp_end_a: assert property (a_match |=> !counter_run_bit && !o_pulse && irq_st_q[PTC_IRQ_A])
    else $error("Compare A did not end pulse");
  flag_sticky_a: assert property (irq_st_q[0] && !(wr_clr && i_wdata[0]) |=> irq_st_q[0])
    else $error("Flag lost without clear");
  irq_clear_a: assert property (wr_clr && i_wdata[0] && !irq_set[0] |=> !irq_st_q[0])
    else $error("Flag not cleared by write");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  cap_seen_c:   cover property (cap_evt);
  per_seen_c:   cover property (per_match);
  sp_seen_c:    cover property (sp_auto ##[1:20] a_match);
  irq_seen_c:   cover property (o_irq);
  wrap_seen_c:  cover property (count_en && cnt_q == '1);

endmodule

// ---- tb/ptc_pin_model.sv ----
// Pin driver standing in for the outside signals on the capture and trigger pins.
// Assumes the bench calls drive() right after a clock edge; pins are asynchronous.
`timescale 1ns/1ns
module ptc_pin_model
#(
  parameter int SKEW_NS = 7
)
(
  output logic o_cap,
  output logic o_trig
);
  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  // Skew keeps pin changes away from the sampling edge, as a real pin would be
  initial
  begin
    o_cap  = 1'b0;
    o_trig = 1'b0;
  end

  task automatic drive(input bit sel, input logic v);
    #(SKEW_NS);
    if (sel)
      o_trig = v;
    else
      o_cap = v;
  endtask
endmodule

// ---- tb/test_periodic_timer_capture_pulse.sv ----
// Self-checking bench for the timer block: capture mode, period and single pulse.
// Assumes ptc_pkg offsets and the pin model in tb/ptc_pin_model.sv.
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module test_periodic_timer_capture_pulse;
  import ptc_pkg::*;
  logic       clk, nrst, ce, tick, wr, rd, cap, trig, pulse, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, v, lo, hi;
  int         err_total, tests_run, cyc;
  // ----------------------------------------------------------------
  // Design and pins
  // ----------------------------------------------------------------
  ptc_timer dut (.i_ref_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_tick(tick), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_capture_input_pin(cap),
    .i_ext_trigger_pin(trig), .o_pulse(pulse), .o_irq(irq));
  ptc_pin_model u_pins (.o_cap(cap), .o_trig(trig));
  // ----------------------------------------------------------------
  // Clock, timeout, bus tasks
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Whole run is a few hundred cycles; the ceiling leaves wide margin
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      complete_run();
    end
  end
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk); wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk); wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk); rd <= 1'b1; addr <= a;
    @(posedge clk); rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(input string n, input logic [3:0] a, input logic [7:0] e);
    rd_reg(a, v);
    `CHK(n, e, v)
  endtask
  // Unused output bits 2:1 set on purpose: capture mode must ignore them
  task automatic cfg(input logic [1:0] m, input logic [1:0] act, input logic src);
    wr_reg(PTC_OFS_CTRL1, {m, act, 1'b0, 2'b11, src});
  endtask
  task automatic pin(input bit sel, input logic lv);
    u_pins.drive(sel, lv);
    repeat (6) @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_capture();
    for (int a = 0; a < 12; a++) rd_chk("reset_val", a[3:0], 8'h00);
    cfg(PTC_MODE_CAPTURE, PTC_ACT_RISE, 1'b0);
    wr_reg(PTC_OFS_IRQ_EN, 8'h01);
    tick <= 1'b1;
    wr_reg(PTC_OFS_CTRL0, 8'h09);
    repeat (20) @(posedge clk);
    tick <= 1'b0;
    repeat (2) @(posedge clk);
    rd_reg(PTC_OFS_CNT_L, lo);
    rd_reg(PTC_OFS_CNT_H, hi);
    `CHK("cnt_runs", 1'b1, lo != 8'h00)
    pin(0, 1'b1);
    rd_chk("cmpa_lo", PTC_OFS_CMPA_L, lo);
    rd_chk("cmpa_hi", PTC_OFS_CMPA_H, hi);
    rd_chk("st_cap", PTC_OFS_IRQ_ST, 8'h01);
    `CHK("irq_on", 1'b1, irq)
    wr_reg(PTC_OFS_IRQ_EN, 8'h00);
    #1;
    `CHK("irq_masked", 1'b0, irq)
    rd_chk("st_sticky", PTC_OFS_IRQ_ST, 8'h01);
    tick <= 1'b1;
    repeat (7) @(posedge clk);
    tick <= 1'b0;
    repeat (2) @(posedge clk);
    rd_reg(PTC_OFS_CNT_L, lo);
    pin(0, 1'b0);
    pin(0, 1'b1);
    rd_chk("cmpa_new", PTC_OFS_CMPA_L, lo);
    wr_reg(PTC_OFS_IRQ_EN, 8'h01);
    wr_reg(PTC_OFS_IRQ_CLR, 8'h03);
    rd_chk("st_clr", PTC_OFS_IRQ_ST, 8'h00);
    `CHK("irq_off", 1'b0, irq)
    $display("test capture done");
  endtask
  task automatic t_edges();
    for (int m = 0; m < 4; m++)
    begin
      cfg(PTC_MODE_CAPTURE, m[1:0], 1'b0);
      pin(0, 1'b0);
      wr_reg(PTC_OFS_IRQ_CLR, 8'h03);
      pin(0, 1'b1);
      rd_chk("rise_cap", PTC_OFS_IRQ_ST, {7'h0, m == 0 || m == 2});
      wr_reg(PTC_OFS_IRQ_CLR, 8'h03);
      pin(0, 1'b0);
      rd_chk("fall_cap", PTC_OFS_IRQ_ST, {7'h0, m == 1 || m == 2});
    end
    cfg(PTC_MODE_CAPTURE, PTC_ACT_BOTH, 1'b1);
    wr_reg(PTC_OFS_IRQ_CLR, 8'h03);
    pin(0, 1'b1);
    rd_chk("src_other", PTC_OFS_IRQ_ST, 8'h00);
    pin(1, 1'b1);
    rd_chk("src_trig", PTC_OFS_IRQ_ST, 8'h01);
    pin(1, 1'b0);
    $display("test edges done");
  endtask
  task automatic t_period();
    wr_reg(PTC_OFS_CTRL0, 8'h01);
    wr_reg(PTC_OFS_PER_H, 8'hFF);
    rd_chk("per_hi", PTC_OFS_PER_H, 8'h03);
    wr_reg(PTC_OFS_PER_H, 8'h00);
    wr_reg(PTC_OFS_PER_L, 8'h05);
    wr_reg(PTC_OFS_IRQ_CLR, 8'h03);
    tick <= 1'b1;
    wr_reg(PTC_OFS_CTRL0, 8'h09);
    repeat (30) @(posedge clk);
    rd_chk("per_flag", PTC_OFS_IRQ_ST, 8'h02);
    rd_reg(PTC_OFS_CNT_L, v);
    `CHK("cnt_bound", 1'b1, v <= 8'h05)
    wr_reg(PTC_OFS_CTRL0, 8'h01);
    wr_reg(PTC_OFS_PER_L, 8'h00);
    wr_reg(PTC_OFS_IRQ_CLR, 8'h03);
    wr_reg(PTC_OFS_CTRL0, 8'h09);
    repeat (30) @(posedge clk);
    rd_reg(PTC_OFS_CNT_L, v);
    `CHK("cnt_full", 1'b1, v > 8'h05)
    rd_chk("per_zero", PTC_OFS_IRQ_ST, 8'h00);
    wr_reg(PTC_OFS_CTRL0, 8'h01);
    rd_reg(PTC_OFS_CNT_L, lo);
    repeat (5) @(posedge clk);
    rd_chk("cnt_stop", PTC_OFS_CNT_L, lo);
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(PTC_OFS_PER_L, 8'h5A);
    ce <= 1'b1;
    rd_chk("ce_freeze", PTC_OFS_PER_L, 8'h00);
    $display("test period done");
  endtask
  task automatic t_pulse();
    wr_reg(PTC_OFS_CMPA_L, 8'h08);
    cfg(PTC_MODE_PWM_SP, PTC_ACT_NONE, 1'b0);
    wr_reg(PTC_OFS_IRQ_CLR, 8'h03);
    `CHK("pulse_idle", 1'b0, pulse)
    pin(1, 1'b1);
    `CHK("pulse_trig", 1'b1, pulse)
    repeat (20) @(posedge clk);
    `CHK("pulse_end", 1'b0, pulse)
    rd_chk("pulse_flag", PTC_OFS_IRQ_ST, 8'h01);
    wr_reg(PTC_OFS_CTRL0, 8'h08);
    repeat (3) @(posedge clk);
    `CHK("pulse_sw", 1'b1, pulse)
    $display("test pulse done");
  endtask
  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    {nrst, tick, wr, rd, addr, wdata} = '0;
    ce = 1'b1;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_capture();
    t_edges();
    t_period();
    t_pulse();
    complete_run();
  end
endmodule
